// *** bus_path_pkg.sv ***
// constants shared by the timer cluster bus access path
package bus_path_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int STAT_W = 2;
  localparam int PLL_AW = 6;
  // bus answer status codes
  localparam logic [1:0] STAT_OK = 2'h0;
  localparam logic [1:0] STAT_ERR = 2'h2;
  // register map (byte addresses)
  localparam logic [15:0] OFS_NOTIFY = 16'h0000;
  localparam logic [15:0] OFS_IRQ_EN = 16'h0004;
  localparam logic [15:0] OFS_IRQ_CLR = 16'h0008;
  localparam logic [15:0] OFS_XPT = 16'h000C;
  localparam logic [15:0] OFS_CTRL = 16'h0010;
  localparam logic [15:0] OFS_AUX_SRC = 16'h0100;
  localparam logic [15:0] OFS_CAP_EN = 16'h0104;
  localparam logic [15:0] OFS_PLL_BASE = 16'h0200;
  localparam logic [15:0] OFS_PLL_END = 16'h02FC;
  // notify bit positions
  localparam int NTF_XPT = 0;
  localparam int NTF_W = 1;
  // control bit positions
  localparam int CTRL_CL0_EN = 0;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
endpackage

// *** bus_access_path.sv ***
// register-bus access path of a timer cluster: mux, error capture, pll ram
`timescale 1ns/1ps
module bus_access_path
  import bus_path_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // processor register port
  input wire logic [bus_path_pkg::ADDR_W-1:0] cpu_addr,
  input wire logic [bus_path_pkg::DATA_W-1:0] cpu_wdata,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  output logic [bus_path_pkg::DATA_W-1:0] cpu_rdata,
  output logic [bus_path_pkg::STAT_W-1:0] cpu_status,
  // channel sequencer master port
  input wire logic [bus_path_pkg::ADDR_W-1:0] seq_addr,
  input wire logic [bus_path_pkg::DATA_W-1:0] seq_wdata,
  input wire logic seq_wr,
  input wire logic seq_rd,
  output logic [bus_path_pkg::DATA_W-1:0] seq_rdata,
  output logic seq_ack,
  // debug halt request, from another domain
  input wire logic halt_req,
  // interrupt
  output logic irq
);
  import bus_path_pkg::*;

  localparam int PLL_DEPTH = 1 << PLL_AW;

  ////////////////////////////////////////////////////////////////////////
  // synchroniser and arbitration
  logic halt_s1_reg;
  logic halt_s2_reg;
  logic halt_d_reg;
  logic halted;
  logic halt_rise;
  logic halt_fall;

  // halt request passes two flops
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      halt_s1_reg <= 1'b0;
      halt_s2_reg <= 1'b0;
      halt_d_reg <= 1'b0;
    end else begin
      halt_s1_reg <= halt_req;
      halt_s2_reg <= halt_s1_reg;
      halt_d_reg <= halt_s2_reg;
    end
  end
  assign halted = halt_s2_reg;
  assign halt_rise = halt_s2_reg & ~halt_d_reg;
  assign halt_fall = ~halt_s2_reg & halt_d_reg;

  // sequencer has priority; a parked processor request waits until seq_go is low
  logic seq_go;
  logic cpu_pend_reg;
  logic [ADDR_W-1:0] cpu_addr_reg;
  logic [DATA_W-1:0] cpu_wdata_reg;
  logic cpu_wr_reg;
  logic cpu_go;
  logic [ADDR_W-1:0] c_addr;
  logic [DATA_W-1:0] c_wdata;
  logic c_wr;

  assign seq_go = (seq_wr | seq_rd) & ~halted;
  assign c_addr = cpu_pend_reg ? cpu_addr_reg : cpu_addr;
  assign c_wdata = cpu_pend_reg ? cpu_wdata_reg : cpu_wdata;
  assign c_wr = cpu_pend_reg ? cpu_wr_reg : cpu_wr;
  assign cpu_go = (cpu_pend_reg | cpu_wr | cpu_rd) & ~seq_go;

  // park a processor request that lost arbitration
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cpu_pend_reg <= 1'b0;
      cpu_addr_reg <= '0;
      cpu_wdata_reg <= '0;
      cpu_wr_reg <= 1'b0;
    end else if (seq_go && (cpu_wr || cpu_rd) && !cpu_pend_reg) begin
      cpu_pend_reg <= 1'b1;
      cpu_addr_reg <= cpu_addr;
      cpu_wdata_reg <= cpu_wdata;
      cpu_wr_reg <= cpu_wr;
    end else if (cpu_go) begin
      cpu_pend_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // address decode
  function automatic logic is_pll(input logic [ADDR_W-1:0] a);
    return (a >= OFS_PLL_BASE) && (a <= OFS_PLL_END);
  endfunction

  function automatic logic is_legacy(input logic [ADDR_W-1:0] a);
    return (a == OFS_AUX_SRC) || (a == OFS_CAP_EN);
  endfunction

  function automatic logic [PLL_AW-1:0] pll_idx(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] d;
    d = a - OFS_PLL_BASE;
    return d[PLL_AW+1:2];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [DATA_W-1:0] ctrl_reg;
  logic [DATA_W-1:0] aux_src_reg;
  logic [DATA_W-1:0] cap_en_reg;
  logic [NTF_W-1:0] notify_reg;
  logic [NTF_W-1:0] irq_en_reg;
  logic [ADDR_W-1:0] xpt_addr_reg;
  logic xpt_valid_reg;
  logic cl0_en;
  logic err_now;
  logic xpt_rd;

  assign cl0_en = ctrl_reg[CTRL_CL0_EN];
  // faulty answer: legacy write while cluster 0 off
  assign err_now = cpu_go && c_wr && is_legacy(c_addr) && !cl0_en;
  assign xpt_rd = cpu_go && !c_wr && (c_addr == OFS_XPT);

  // plain control and legacy registers; legacy write still lands
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_reg <= CTRL_RST;
      aux_src_reg <= '0;
      cap_en_reg <= '0;
      irq_en_reg <= '0;
    end else if (cpu_go && c_wr) begin
      case (c_addr)
        OFS_CTRL: ctrl_reg <= c_wdata;
        OFS_AUX_SRC: aux_src_reg <= c_wdata;
        OFS_CAP_EN: cap_en_reg <= c_wdata;
        OFS_IRQ_EN: irq_en_reg <= c_wdata[NTF_W-1:0];
        default: ;
      endcase
    end
  end

  // sticky notify flag; set wins over clear
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      notify_reg <= '0;
    end else begin
      if (cpu_go && c_wr && c_addr == OFS_IRQ_CLR) begin
        notify_reg <= notify_reg & ~c_wdata[NTF_W-1:0];
      end
      if (err_now) begin
        notify_reg[NTF_XPT] <= 1'b1;
      end
    end
  end

  // exception address capture, held until read
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      xpt_addr_reg <= '0;
      xpt_valid_reg <= 1'b0;
    end else if (err_now && !xpt_valid_reg) begin
      xpt_addr_reg <= c_addr;
      xpt_valid_reg <= 1'b1;
    end else if (xpt_rd) begin
      xpt_addr_reg <= '0;
      xpt_valid_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pll ram with halt snapshot and restore
  logic [DATA_W-1:0] pll_mem [PLL_DEPTH];
  logic snap_valid_reg;
  logic [PLL_AW-1:0] snap_idx_reg;
  logic [DATA_W-1:0] snap_data_reg;
  logic seq_pll_wr;
  logic cpu_pll_wr;

  assign seq_pll_wr = seq_go && seq_wr && is_pll(seq_addr);
  assign cpu_pll_wr = cpu_go && c_wr && is_pll(c_addr);

  // catch the sequencer write in flight at halt entry
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      snap_valid_reg <= 1'b0;
      snap_idx_reg <= '0;
      snap_data_reg <= '0;
    end else if (halt_fall) begin
      snap_valid_reg <= 1'b0;
    end else if (halt_rise && seq_wr && is_pll(seq_addr)) begin
      snap_valid_reg <= 1'b1;
      snap_idx_reg <= pll_idx(seq_addr);
      snap_data_reg <= seq_wdata;
    end else if (halted && cpu_pll_wr && snap_valid_reg) begin
      snap_data_reg <= c_wdata;
    end
  end

  // ram writes; reads never modify contents
  always_ff @(posedge core_clk) begin
    if (halt_fall && snap_valid_reg) begin
      pll_mem[snap_idx_reg] <= snap_data_reg;
    end else if (seq_pll_wr) begin
      pll_mem[pll_idx(seq_addr)] <= seq_wdata;
    end else if (cpu_pll_wr) begin
      pll_mem[pll_idx(c_addr)] <= c_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data and answers
  logic [DATA_W-1:0] cpu_rd_next;
  logic [STAT_W-1:0] cpu_stat_next;

  always_comb begin
    cpu_rd_next = '0;
    case (c_addr)
      OFS_NOTIFY: cpu_rd_next = DATA_W'(notify_reg);
      OFS_IRQ_EN: cpu_rd_next = DATA_W'(irq_en_reg);
      OFS_XPT: cpu_rd_next = DATA_W'(xpt_addr_reg);
      OFS_CTRL: cpu_rd_next = ctrl_reg;
      OFS_AUX_SRC: cpu_rd_next = cl0_en ? aux_src_reg : '0;
      OFS_CAP_EN: cpu_rd_next = cl0_en ? cap_en_reg : '0;
      default: cpu_rd_next = is_pll(c_addr) ? pll_mem[pll_idx(c_addr)] : '0;
    endcase
    cpu_stat_next = err_now ? STAT_ERR : STAT_OK;
  end

  // processor answer one cycle after its access is served
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cpu_rdata <= '0;
      cpu_status <= STAT_OK;
    end else begin
      cpu_rdata <= (cpu_go && !c_wr) ? cpu_rd_next : '0;
      cpu_status <= cpu_go ? cpu_stat_next : STAT_OK;
    end
  end

  // sequencer answer; zero-wait targets only
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      seq_rdata <= '0;
      seq_ack <= 1'b0;
    end else begin
      seq_ack <= seq_go;
      seq_rdata <= (seq_go && seq_rd && is_pll(seq_addr)) ?
                   pll_mem[pll_idx(seq_addr)] : '0;
    end
  end

  // level interrupt
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(notify_reg & irq_en_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  // helpers for the ram checks
  logic [PLL_AW-1:0] cpu_idx;
  logic [DATA_W-1:0] cpu_pll_word;
  assign cpu_idx = pll_idx(c_addr);
  assign cpu_pll_word = pll_mem[cpu_idx];

  a_err_status: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    err_now |=> cpu_status == STAT_ERR)
    else $error("faulty legacy write not answered with status 2");

  a_err_notify: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    err_now |=> notify_reg[NTF_XPT])
    else $error("notify flag not set on error answer");

  a_xpt_capture: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    err_now && !xpt_valid_reg |=> xpt_addr_reg == $past(c_addr))
    else $error("error address not captured");

  a_xpt_hold: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    xpt_valid_reg && !xpt_rd |=> $stable(xpt_addr_reg))
    else $error("captured address overwritten");

  a_xpt_clear: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    xpt_rd && !err_now |=> !xpt_valid_reg)
    else $error("exception status not cleared by read");

  a_legacy_zero: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    cpu_go && !c_wr && is_legacy(c_addr) && !cl0_en |=> cpu_rdata == '0)
    else $error("legacy read with cluster off not zero");

  a_ok_status: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    cpu_go && !err_now |=> cpu_status == STAT_OK)
    else $error("nonzero status without error");

  sequence halt_caught_s;
    halt_rise && seq_wr && is_pll(seq_addr);
  endsequence
  a_snap_catch: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    halt_caught_s |=> snap_valid_reg)
    else $error("sequencer write at halt not caught");

  a_restore_write: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    halt_fall && snap_valid_reg |=>
      pll_mem[$past(snap_idx_reg)] == $past(snap_data_reg))
    else $error("caught entry not written back at halt exit");

  a_debug_replace: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    halted && !halt_rise && cpu_pll_wr && snap_valid_reg |=>
      snap_data_reg == $past(c_wdata))
    else $error("debug write did not replace caught data");

  a_pll_read_keeps: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    halted && cpu_go && !c_wr && is_pll(c_addr) |=>
      pll_mem[$past(cpu_idx)] == $past(cpu_pll_word))
    else $error("halted read changed ram contents");

  a_seq_refused: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    halted |=> !seq_ack)
    else $error("sequencer access answered while halted");

  a_irq_level: assert property (@(posedge core_clk) disable iff (!rst_b)
    |(notify_reg & irq_en_reg) |=> irq)
    else $error("interrupt not raised");

endmodule // bus_access_path

// *** seq_master_model.sv ***
// sequencer master model for the bus path's master port
`timescale 1ns/1ps
module seq_master_model
  import bus_path_pkg::*;
(
  // clock
  input wire logic core_clk,
  // master port
  output logic [bus_path_pkg::ADDR_W-1:0] seq_addr,
  output logic [bus_path_pkg::DATA_W-1:0] seq_wdata,
  output logic seq_wr,
  output logic seq_rd,
  input wire logic [bus_path_pkg::DATA_W-1:0] seq_rdata,
  input wire logic seq_ack
);
  // idle port at time zero
  initial begin
    seq_addr = '0;
    seq_wdata = '0;
    seq_wr = 1'b0;
    seq_rd = 1'b0;
  end
  // one access in flight at a time, from a single thread, to zero-wait words
  task automatic access(input logic wr, input logic [15:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic ok);
    @(posedge core_clk);
    seq_addr <= {a[15:2], 2'h0};
    seq_wdata <= d;
    seq_wr <= wr;
    seq_rd <= !wr;
    @(posedge core_clk);
    seq_wr <= 1'b0;
    seq_rd <= 1'b0;
    seq_addr <= ~a;
    seq_wdata <= ~d;
    #1;
    ok = seq_ack;
    q = seq_rdata;
  endtask
endmodule // seq_master_model

// *** timer_ip_bus_access_path_bench.sv ***
// self-checking bench for the timer cluster bus access path
`timescale 1ns/1ps
module timer_ip_bus_access_path_bench;
  import bus_path_pkg::*;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [15:0] cpu_addr = '0;
  logic [31:0] cpu_wdata = '0;
  logic cpu_wr = 1'b0;
  logic cpu_rd = 1'b0;
  logic [31:0] cpu_rdata;
  logic [1:0] cpu_status;
  logic [15:0] seq_addr;
  logic [31:0] seq_wdata;
  logic seq_wr;
  logic seq_rd;
  logic [31:0] seq_rdata;
  logic seq_ack;
  logic halt_req = 1'b0;
  logic irq;
  logic [31:0] q;
  logic ok;
  int bad_count = 0;
  int tests_run = 0;
  ////////////////////////////////////////////////////////////////////////////
  // clock and instances
  always #5 core_clk = ~core_clk;
  bus_access_path bus_access_path_i (.core_clk(core_clk), .rst_b(rst_b),
    .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr),
    .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata), .cpu_status(cpu_status),
    .seq_addr(seq_addr), .seq_wdata(seq_wdata), .seq_wr(seq_wr),
    .seq_rd(seq_rd), .seq_rdata(seq_rdata), .seq_ack(seq_ack),
    .halt_req(halt_req), .irq(irq));
  seq_master_model seq_master_model_i (.core_clk(core_clk),
    .seq_addr(seq_addr), .seq_wdata(seq_wdata), .seq_wr(seq_wr),
    .seq_rd(seq_rd), .seq_rdata(seq_rdata), .seq_ack(seq_ack));
  ////////////////////////////////////////////////////////////////////////////
  // compare and report
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // one processor access, to zero-wait targets only
  task automatic cpu(input logic wr, input logic [15:0] a,
    input logic [31:0] d, input logic [1:0] st);
    @(posedge core_clk);
    cpu_addr <= a;
    cpu_wdata <= d;
    cpu_wr <= wr;
    cpu_rd <= !wr;
    @(posedge core_clk);
    cpu_wr <= 1'b0;
    cpu_rd <= 1'b0;
    #1;
    check({30'h0, cpu_status}, {30'h0, st});
    if (!wr) check(cpu_rdata, d);
  endtask
  task automatic irq_is(input logic v);
    @(posedge core_clk);
    #1;
    check({31'h0, irq}, {31'h0, v});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    #20000;
    bad_count++;
    tally_and_finish();
  end
  // test sequence
  initial begin
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    cpu(1'b0, OFS_CTRL, CTRL_RST, STAT_OK);
    cpu(1'b0, OFS_NOTIFY, 32'h0, STAT_OK);
    $display("reset values done");
    cpu(1'b1, OFS_IRQ_EN, 32'h1, STAT_OK);
    cpu(1'b1, OFS_CTRL, 32'h0, STAT_OK);
    cpu(1'b1, OFS_AUX_SRC, 32'h5A, STAT_ERR);
    irq_is(1'b1);
    cpu(1'b0, OFS_NOTIFY, 32'h1, STAT_OK);
    cpu(1'b1, OFS_CAP_EN, 32'h3, STAT_ERR);
    cpu(1'b0, OFS_XPT, {16'h0, OFS_AUX_SRC}, STAT_OK);
    cpu(1'b0, OFS_XPT, 32'h0, STAT_OK);
    cpu(1'b0, OFS_AUX_SRC, 32'h0, STAT_OK);
    cpu(1'b0, OFS_CAP_EN, 32'h0, STAT_OK);
    // capture is armed again after the clearing read
    cpu(1'b1, OFS_CAP_EN, 32'h3, STAT_ERR);
    cpu(1'b0, OFS_XPT, {16'h0, OFS_CAP_EN}, STAT_OK);
    cpu(1'b1, OFS_IRQ_CLR, 32'h1, STAT_OK);
    irq_is(1'b0);
    cpu(1'b1, OFS_CTRL, 32'h1, STAT_OK);
    cpu(1'b0, OFS_AUX_SRC, 32'h5A, STAT_OK);
    cpu(1'b0, OFS_CAP_EN, 32'h3, STAT_OK);
    cpu(1'b1, OFS_AUX_SRC, 32'hA5, STAT_OK);
    cpu(1'b0, OFS_XPT, 32'h0, STAT_OK);
    cpu(1'b0, 16'h0F00, 32'h0, STAT_OK);
    $display("error capture done");
    seq_master_model_i.access(1'b1, 16'h0204, 32'h11, q, ok);
    check({31'h0, ok}, 32'h1);
    seq_master_model_i.access(1'b0, 16'h0204, 32'h0, q, ok);
    check(q, 32'h11);
    // a processor write that meets a sequencer access is parked
    fork
      seq_master_model_i.access(1'b1, 16'h0214, 32'h66, q, ok);
      cpu(1'b1, OFS_IRQ_EN, 32'h0, STAT_OK);
    join
    check({31'h0, ok}, 32'h1);
    cpu(1'b0, 16'h0214, 32'h66, STAT_OK);
    cpu(1'b0, OFS_IRQ_EN, 32'h0, STAT_OK);
    cpu(1'b1, OFS_IRQ_EN, 32'h1, STAT_OK);
    $display("arbitration done");
    // sequencer write meets halt entry; a debug write corrupts it
    @(posedge core_clk);
    halt_req <= 1'b1;
    @(posedge core_clk);
    seq_master_model_i.access(1'b1, 16'h0208, 32'h77, q, ok);
    check({31'h0, ok}, 32'h0);
    cpu(1'b1, 16'h020C, 32'h22, STAT_OK);
    cpu(1'b0, 16'h0204, 32'h11, STAT_OK);
    cpu(1'b0, 16'h020C, 32'h22, STAT_OK);
    @(posedge core_clk);
    halt_req <= 1'b0;
    repeat (3) @(posedge core_clk);
    cpu(1'b0, 16'h0208, 32'h22, STAT_OK);
    cpu(1'b0, 16'h020C, 32'h22, STAT_OK);
    // same again, with the caught word rewritten before resuming
    @(posedge core_clk);
    halt_req <= 1'b1;
    @(posedge core_clk);
    seq_master_model_i.access(1'b1, 16'h0210, 32'h55, q, ok);
    check({31'h0, ok}, 32'h0);
    cpu(1'b1, 16'h020C, 32'h33, STAT_OK);
    cpu(1'b1, 16'h0210, 32'h55, STAT_OK);
    @(posedge core_clk);
    halt_req <= 1'b0;
    repeat (3) @(posedge core_clk);
    cpu(1'b0, 16'h0210, 32'h55, STAT_OK);
    cpu(1'b0, 16'h020C, 32'h33, STAT_OK);
    cpu(1'b0, 16'h0208, 32'h22, STAT_OK);
    $display("halt and restore done");
    tally_and_finish();
  end
endmodule // timer_ip_bus_access_path_bench
